// File: bsgp_top.sv
// pin level control for boot strap, bank bit, general pins, serial sharing, memory select
`timescale 1ns/1ns
// Summary of operation
// - boot pin pull-up on during reset, released a few cycles after release.
// - boot pin level captured at reset release, readable in boot rom select status.
// - captured high selects internal rom, low selects external memory.
// - after release the boot pin serves as general pin six or serial receive.
// - bank address bit maps upper half of 128k memory into 64k space.
// - each interrupt pin is input, edge interrupt input or output.
// - pin twelve is input or output only, never interrupting.
// - three pins choose general use or card supply, driver follows choice.
// - infrared speed output shows currently selected link speed.
// - serial pins switch between infrared transceiver and plain uart.
// - program memory select asserted once the pull-up phase ends, except during controller standby.
// - program memory select held high throughout chip reset.
module bsgp_top #(
  parameter int unsigned GPIO_N = bsgp_pkg::GPIO_COUNT,
  parameter int unsigned IRQ_N  = bsgp_pkg::IRQ_COUNT
) (
  // clock and reset
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst_n,
  // general pins, index 0 is pin one
  input  wire logic [GPIO_N-1:0]         i_gpio_pin,
  output logic      [GPIO_N-1:0]         o_gpio_out,
  output logic      [GPIO_N-1:0]         o_gpio_oe,
  output logic                           o_boot_pullup_en,
  // pin configuration, two bits per pin
  input  wire logic [2*GPIO_N-1:0]       i_gpio_mode,
  input  wire logic [GPIO_N-1:0]         i_gpio_out_val,
  input  wire logic [IRQ_N-1:0]          i_irq_rise,
  input  wire logic [IRQ_N-1:0]          i_irq_clear,
  // card supply sharing
  input  wire logic [2:0]                i_card_sel_wr,
  input  wire logic [2:0]                i_card_sel_val,
  input  wire logic [2:0]                i_card_supply_on,
  // serial sharing and infrared speed
  input  wire logic                      i_ir_sel_wr,
  input  wire logic                      i_ir_sel_val,
  input  wire logic [bsgp_pkg::SPEED_W-1:0] i_ir_speed,
  input  wire logic                      i_uart_tx,
  input  wire logic                      i_ir_tx,
  input  wire logic                      i_serial_rx_pin,
  input  wire logic                      i_rx_on_boot_pin,
  output logic                           o_serial_tx_pin,
  output logic [bsgp_pkg::SPEED_W-1:0]   o_infrared_speed_out,
  output bsgp_pkg::bsgp_serial_rx_t      o_serial_rx,
  // memory control
  input  wire logic                      i_bank_upper,
  input  wire logic                      i_mcu_standby,
  output logic                           o_bank_address_bit,
  output logic                           o_program_mem_select_low,
  output logic                           o_boot_from_rom,
  // status
  output logic [GPIO_N-1:0]              o_general_input_reg_one,
  output logic                           o_boot_rom_select,
  output logic [IRQ_N-1:0]               o_irq_flags,
  output logic                           o_irq_request
);
  localparam int unsigned C8  = 7;
  localparam int unsigned C10 = 9;
  localparam int unsigned C11 = 10;

  logic rst_meta_reg, rst_sync_reg;
  logic rst_n_s;

  // reset is released through two flops, asserted at once
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n_s = rst_sync_reg;

  // phase of reset release
  bsgp_pkg::bsgp_phase_t         phase_reg, phase_next;
  logic [bsgp_pkg::HOLD_CNT_W-1:0] hold_reg, hold_next;
  logic                          boot_reg, boot_next;

  always_comb begin
    phase_next = phase_reg;
    hold_next  = hold_reg;
    boot_next  = boot_reg;
    case (phase_reg)
      bsgp_pkg::BSGP_PH_RESET: begin
        // strap caught on the first clock after release
        boot_next  = i_gpio_pin[bsgp_pkg::BOOT_PIN_IDX];
        hold_next  = '0;
        phase_next = bsgp_pkg::BSGP_PH_HOLD;
      end
      bsgp_pkg::BSGP_PH_HOLD: begin
        if (hold_reg == bsgp_pkg::HOLD_CNT_W'(bsgp_pkg::PULLUP_HOLD_CYC - 1)) begin
          phase_next = bsgp_pkg::BSGP_PH_RUN;
        end else begin
          hold_next = hold_reg + 1'b1;
        end
      end
      bsgp_pkg::BSGP_PH_RUN: begin
        phase_next = bsgp_pkg::BSGP_PH_RUN;
      end
      default: begin
        phase_next = bsgp_pkg::BSGP_PH_RESET;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      phase_reg <= bsgp_pkg::BSGP_PH_RESET;
      hold_reg  <= '0;
      boot_reg  <= bsgp_pkg::BOOT_INTERNAL;
    end else begin
      phase_reg <= phase_next;
      hold_reg  <= hold_next;
      boot_reg  <= boot_next;
    end
  end

  logic running;
  assign running = (phase_reg == bsgp_pkg::BSGP_PH_RUN);

  // shared function selection
  logic [2:0] card_sel_reg, card_sel_next;
  logic       ir_sel_reg, ir_sel_next;

  always_comb begin
    card_sel_next = card_sel_reg;
    ir_sel_next   = ir_sel_reg;
    for (int k = 0; k < bsgp_pkg::CARD_COUNT; k++) begin
      if (i_card_sel_wr[k]) begin
        card_sel_next[k] = i_card_sel_val[k];
      end
    end
    if (i_ir_sel_wr) begin
      ir_sel_next = i_ir_sel_val;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      card_sel_reg <= bsgp_pkg::CARD_SEL_RESET;
      ir_sel_reg   <= bsgp_pkg::IR_SEL_RESET;
    end else begin
      card_sel_reg <= card_sel_next;
      ir_sel_reg   <= ir_sel_next;
    end
  end

  // edge detectors on interrupt capable pins; pin twelve has none
  logic [IRQ_N-1:0] flags;
  genvar g;
  generate
    for (g = 0; g < IRQ_N; g++) begin : g_edge
      bsgp_edge_cell u_cell (
        .i_clk_sys    (i_clk_sys),
        .i_rst_n      (rst_n_s),
        .i_irq_mode   (running && (i_gpio_mode[2*g +: 2] == bsgp_pkg::MODE_IRQ)),
        .i_rise_edge  (i_irq_rise[g]),
        .i_flag_clear (i_irq_clear[g]),
        .i_pin        (i_gpio_pin[g]),
        .o_flag       (flags[g])
      );
    end
  endgenerate

  // pad and status values, all registered
  bsgp_pkg::bsgp_pad_t               pad_reg, pad_next;
  logic [GPIO_N-1:0]                 in_reg, in_next;
  logic                              pull_reg, pull_next;
  logic                              tx_reg, tx_next;
  logic [bsgp_pkg::SPEED_W-1:0]      spd_reg, spd_next;
  bsgp_pkg::bsgp_serial_rx_t         rx_reg, rx_next;
  logic                              bank_reg, bank_next;
  logic                              msel_reg, msel_next;
  logic [IRQ_N-1:0]                  flag_out_reg, flag_out_next;
  logic                              irq_reg, irq_next;

  always_comb begin
    logic rx_src;
    rx_src = 1'b1;
    for (int p = 0; p < GPIO_N; p++) begin
      // pin twelve treats the interrupt code as plain input
      pad_next.oe[p]  = running && (i_gpio_mode[2*p +: 2] == bsgp_pkg::MODE_OUTPUT);
      pad_next.out[p] = i_gpio_out_val[p];
    end
    // boot pin stays an input while it carries serial receive after the pull-up phase
    if (running && i_rx_on_boot_pin) begin
      pad_next.oe[bsgp_pkg::BOOT_PIN_IDX] = 1'b0;
    end
    // card supply takes over the driver of its pin
    if (card_sel_reg[0]) begin
      pad_next.oe[C8]  = 1'b1;
      pad_next.out[C8] = i_card_supply_on[0];
    end
    if (card_sel_reg[1]) begin
      pad_next.oe[C10]  = 1'b1;
      pad_next.out[C10] = i_card_supply_on[1];
    end
    if (card_sel_reg[2]) begin
      pad_next.oe[C11]  = 1'b1;
      pad_next.out[C11] = i_card_supply_on[2];
    end
    in_next    = i_gpio_pin;
    in_next[bsgp_pkg::BOOT_PIN_IDX] = i_gpio_pin[bsgp_pkg::BOOT_PIN_IDX];
    pull_next  = !running;
    // serial receive from dedicated pin or from the boot pin
    rx_src     = (running && i_rx_on_boot_pin) ? i_gpio_pin[bsgp_pkg::BOOT_PIN_IDX] : i_serial_rx_pin;
    rx_next.rx_ir   = ir_sel_reg ? rx_src : 1'b1;
    rx_next.rx_uart = ir_sel_reg ? 1'b1 : rx_src;
    tx_next    = ir_sel_reg ? i_ir_tx : i_uart_tx;
    spd_next   = i_ir_speed;
    // external bank bit only meaningful when booting from external memory
    bank_next  = running && !boot_reg && i_bank_upper;
    msel_next  = (running && !i_mcu_standby) ? bsgp_pkg::MEM_SEL_ACTIVE : bsgp_pkg::MEM_SEL_IDLE;
    flag_out_next = flags;
    irq_next   = |flags;
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pad_reg      <= '0;
      in_reg       <= '0;
      pull_reg     <= 1'b1;
      tx_reg       <= 1'b1;
      spd_reg      <= '0;
      rx_reg       <= '1;
      bank_reg     <= 1'b0;
      msel_reg     <= bsgp_pkg::MEM_SEL_IDLE;
      flag_out_reg <= '0;
      irq_reg      <= 1'b0;
    end else begin
      pad_reg      <= pad_next;
      in_reg       <= in_next;
      pull_reg     <= pull_next;
      tx_reg       <= tx_next;
      spd_reg      <= spd_next;
      rx_reg       <= rx_next;
      bank_reg     <= bank_next;
      msel_reg     <= msel_next;
      flag_out_reg <= flag_out_next;
      irq_reg      <= irq_next;
    end
  end

  assign o_gpio_out               = pad_reg.out;
  assign o_gpio_oe                = pad_reg.oe;
  assign o_boot_pullup_en         = pull_reg;
  assign o_serial_tx_pin          = tx_reg;
  assign o_infrared_speed_out     = spd_reg;
  assign o_serial_rx              = rx_reg;
  assign o_bank_address_bit       = bank_reg;
  assign o_program_mem_select_low = msel_reg;
  assign o_boot_from_rom          = boot_reg;
  assign o_general_input_reg_one  = in_reg;
  assign o_boot_rom_select        = boot_reg;
  assign o_irq_flags              = flag_out_reg;
  assign o_irq_request            = irq_reg;
endmodule // bsgp_top

// File: bsgp_pkg.sv
// package of constants and carrier types for the boot strap and general pin block
package bsgp_pkg;
  localparam int unsigned GPIO_COUNT       = 12;
  localparam int unsigned IRQ_COUNT        = 11;
  localparam int unsigned CARD_COUNT       = 3;
  localparam int unsigned BOOT_PIN_IDX     = 5;
  localparam int unsigned PULLUP_HOLD_CYC  = 4;
  localparam int unsigned HOLD_CNT_W       = 3;
  localparam int unsigned SPEED_W          = 3;
  localparam int          CLK_MHZ          = 100;
  localparam int          RESET_MIN_US     = 1;
  localparam int          RESET_MIN_CYC    = RESET_MIN_US * CLK_MHZ;
  localparam logic        BOOT_INTERNAL    = 1'b1;
  localparam logic        MEM_SEL_IDLE     = 1'b1;
  localparam logic        MEM_SEL_ACTIVE   = 1'b0;
  localparam logic [2:0]  CARD_SEL_RESET   = 3'h0;
  localparam logic        IR_SEL_RESET     = 1'b0;
  localparam logic [1:0]  MODE_INPUT       = 2'h0;
  localparam logic [1:0]  MODE_IRQ         = 2'h1;
  localparam logic [1:0]  MODE_OUTPUT      = 2'h2;

  typedef enum logic [1:0] {
    BSGP_PH_RESET,
    BSGP_PH_HOLD,
    BSGP_PH_RUN
  } bsgp_phase_t;

  // per pin pad signals travel together
  typedef struct packed {
    logic [GPIO_COUNT-1:0] out;
    logic [GPIO_COUNT-1:0] oe;
  } bsgp_pad_t;

  typedef struct packed {
    logic rx_uart;
    logic rx_ir;
  } bsgp_serial_rx_t;
endpackage

// File: bsgp_edge_cell.sv
// one pin edge detector with sticky event flag
`timescale 1ns/1ns
module bsgp_edge_cell (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  // control
  input  wire logic i_irq_mode,
  input  wire logic i_rise_edge,
  input  wire logic i_flag_clear,
  // pin sample
  input  wire logic i_pin,
  // status
  output logic      o_flag
);
  logic last_reg, last_next;
  logic flag_reg, flag_next;
  logic hit;

  always_comb begin
    last_next = i_pin;
    hit       = i_irq_mode & (i_rise_edge ? (i_pin & ~last_reg) : (~i_pin & last_reg));
    // set wins over a clear in the same cycle
    flag_next = hit | (flag_reg & ~i_flag_clear);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      last_reg <= last_next;
      flag_reg <= flag_next;
    end
  end

  assign o_flag = flag_reg;
endmodule // bsgp_edge_cell

// File: bsgp_top_monitor.sv
// timing relations watched at the ports of the pin block
`timescale 1ns/1ns
module bsgp_top_monitor #(
  parameter int unsigned GPIO_N = 12,
  parameter int unsigned IRQ_N  = 11
) (
  input wire logic                 i_clk_sys,
  input wire logic                 i_rst_n,
  input wire logic [2*GPIO_N-1:0]  i_gpio_mode,
  input wire logic [IRQ_N-1:0]     i_irq_clear,
  input wire logic [2:0]           i_ir_speed,
  input wire logic                 i_mcu_standby,
  input wire logic [GPIO_N-1:0]    o_gpio_oe,
  input wire logic                 o_boot_pullup_en,
  input wire logic [2:0]           o_infrared_speed_out,
  input wire logic                 o_program_mem_select_low,
  input wire logic                 o_boot_from_rom,
  input wire logic                 o_boot_rom_select,
  input wire logic                 o_bank_address_bit,
  input wire logic [IRQ_N-1:0]     o_irq_flags,
  input wire logic                 o_irq_request
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_release;
    $rose(i_rst_n);
  endsequence
  // running for two edges, so $past sees only running values
  sequence s_settled;
    !o_boot_pullup_en && !$past(o_boot_pullup_en);
  endsequence
  a_pullup_release: assert property (s_release |-> o_boot_pullup_en ##[1:12] !o_boot_pullup_en)
    else $error("boot pull-up not released in time");
  a_mem_sel_reset: assert property (s_release |-> o_program_mem_select_low && o_gpio_oe == '0)
    else $error("memory select or pin drive wrong at release");
  a_mem_sel_standby: assert property (s_settled |-> o_program_mem_select_low == $past(i_mcu_standby))
    else $error("memory select does not follow standby");
  a_speed_follow: assert property (s_settled |-> o_infrared_speed_out == $past(i_ir_speed))
    else $error("infrared speed output stale");
  a_pin12_plain_io: assert property (s_settled |->
    o_gpio_oe[GPIO_N-1] == ($past(i_gpio_mode[2*GPIO_N-1 -: 2]) == bsgp_pkg::MODE_OUTPUT))
    else $error("pin twelve drive does not follow its mode");
  // strap may only be latched while the pull-up still holds the pin
  a_boot_status_match: assert property ((o_boot_from_rom == o_boot_rom_select) &&
    (!$changed(o_boot_rom_select) || o_boot_pullup_en))
    else $error("boot status differs or changed after pull-up release");
  a_bank_rom_low: assert property (o_boot_from_rom |-> !o_bank_address_bit)
    else $error("bank bit driven while booting internally");
  a_irq_req_or: assert property (o_irq_request == (|o_irq_flags))
    else $error("interrupt request not the or of flags");
  a_flag_clear_only: assert property ($fell(o_irq_flags[0]) |-> $past(i_irq_clear[0], 2))
    else $error("event flag dropped without clear");
endmodule // bsgp_top_monitor

bind bsgp_top bsgp_top_monitor #(.GPIO_N(GPIO_N), .IRQ_N(IRQ_N)) u_mon (.i_clk_sys, .i_rst_n, .i_gpio_mode,
  .i_irq_clear, .i_ir_speed, .i_mcu_standby, .o_gpio_oe, .o_boot_pullup_en, .o_infrared_speed_out,
  .o_program_mem_select_low, .o_boot_from_rom, .o_boot_rom_select, .o_bank_address_bit, .o_irq_flags,
  .o_irq_request);

// File: bsgp_board_model.sv
// board side: straps and outside drivers of the general pins
`timescale 1ns/1ns
module bsgp_board_model (
  input  wire logic        i_clk_sys,
  input  wire logic [11:0] i_out,
  input  wire logic [11:0] i_oe,
  input  wire logic [11:0] i_ext,
  input  wire logic        i_pullup_en,
  input  wire logic        i_strap_open,
  output logic      [11:0] o_pin,
  output logic      [1:0]  o_factory_test_inputs
);
  // test pins tied high so the part stays in normal operation
  assign o_factory_test_inputs = 2'h3;
  logic wander = 1'h0;
  always @(posedge i_clk_sys) wander <= ~wander;
  always_comb begin
    o_pin = (i_oe & i_out) | (~i_oe & i_ext);
    // open strap: only the pull-up holds it, otherwise it floats to no fixed level
    if (!i_oe[5] && i_strap_open) o_pin[5] = i_pullup_en | wander;
  end
endmodule // bsgp_board_model

// File: boot_strap_gpio_pins_tb.sv
// self-checking bench for the boot strap and general pin block
`timescale 1ns/1ns
module boot_strap_gpio_pins_tb;
  logic clk = 1'h0, rst_n = 1'h0, strap_open = 1'h1, ir_wr = 1'h0, ir_val = 1'h0, utx = 1'h1, itx = 1'h1;
  logic rxp = 1'h1, rx_boot = 1'h0, bank = 1'h0, stby = 1'h0, pull, txp, bank_o, msel, rom, romsel, req;
  logic [11:0] ext = 12'h000, out_val = 12'h000, pin, g_out, g_oe, in_reg;
  logic [23:0] mode = 24'h00_0000;
  logic [10:0] rise = 11'h7ff, clr = 11'h000, flags;
  logic [2:0]  cs_wr = 3'h0, cs_val = 3'h0, supply = 3'h0, speed = 3'h0, speed_o;
  bsgp_pkg::bsgp_serial_rx_t rx_o;
  int n_errors = 0, samples_checked = 0;

  bsgp_top DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_gpio_pin(pin), .o_gpio_out(g_out), .o_gpio_oe(g_oe),
    .o_boot_pullup_en(pull), .i_gpio_mode(mode), .i_gpio_out_val(out_val), .i_irq_rise(rise),
    .i_irq_clear(clr), .i_card_sel_wr(cs_wr), .i_card_sel_val(cs_val), .i_card_supply_on(supply),
    .i_ir_sel_wr(ir_wr), .i_ir_sel_val(ir_val), .i_ir_speed(speed), .i_uart_tx(utx), .i_ir_tx(itx),
    .i_serial_rx_pin(rxp), .i_rx_on_boot_pin(rx_boot), .o_serial_tx_pin(txp), .o_infrared_speed_out(speed_o),
    .o_serial_rx(rx_o), .i_bank_upper(bank), .i_mcu_standby(stby), .o_bank_address_bit(bank_o),
    .o_program_mem_select_low(msel), .o_boot_from_rom(rom), .o_general_input_reg_one(in_reg),
    .o_boot_rom_select(romsel), .o_irq_flags(flags), .o_irq_request(req));
  bsgp_board_model u_board (.i_clk_sys(clk), .i_out(g_out), .i_oe(g_oe), .i_ext(ext), .i_pullup_en(pull),
    .i_strap_open(strap_open), .o_pin(pin), .o_factory_test_inputs());

  always #5 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // wide enough for the reset check, which packs two flags with all twelve enables
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // reset pulse held no shorter than the system minimum
  task automatic do_reset(input logic open_strap);
    @(posedge clk);
    rst_n <= 1'h0;
    strap_open <= open_strap;
    ext[5] <= 1'h0;
    tick(3);
    chk({pull, msel, g_oe}, {2'h3, 12'h000});
    tick(bsgp_pkg::RESET_MIN_CYC);
    @(posedge clk);
    rst_n <= 1'h1;
    tick(14);
    chk(pull, 1'h0);
    chk({rom, romsel}, {2{open_strap}});
  endtask

  initial begin
    tick(8);
    do_reset(1'h0);
    @(posedge clk); mode <= 24'h80_0002; out_val <= 12'h801; ext <= 12'h00a;
    tick(4);
    chk(g_oe, 12'h801);
    chk(in_reg, 12'h80b);
    @(posedge clk); mode <= 24'h40_0041; rise <= 11'h7f7;
    tick(4);
    chk(g_oe, 12'h000);
    @(posedge clk); ext <= 12'h803;
    tick(4);
    chk({req, flags}, 12'h809);
    chk(in_reg, 12'h803);
    @(posedge clk); ext <= 12'h002;
    tick(4);
    chk({req, flags}, 12'h809);
    @(posedge clk); clr <= 11'h009;
    @(posedge clk); clr <= 11'h000;
    tick(4);
    chk({req, flags}, 12'h000);
    @(posedge clk); cs_wr <= 3'h1; cs_val <= 3'h1; supply <= 3'h1;
    @(posedge clk); cs_wr <= 3'h0;
    tick(3);
    chk(g_oe & g_out, 12'h080);
    @(posedge clk); utx <= 1'h0; rxp <= 1'h0; speed <= 3'h5;
    tick(3);
    chk({txp, rx_o, speed_o}, 12'h00d);
    @(posedge clk); ir_wr <= 1'h1; ir_val <= 1'h1;
    @(posedge clk); ir_wr <= 1'h0;
    tick(3);
    chk({txp, rx_o}, 12'h006);
    @(posedge clk); rx_boot <= 1'h1; ext[5] <= 1'h1;
    tick(3);
    chk(rx_o, 12'h003);
    @(posedge clk); bank <= 1'h1;
    tick(3);
    chk({bank_o, msel}, 12'h002);
    @(posedge clk); stby <= 1'h1;
    tick(3);
    chk(msel, 12'h001);
    do_reset(1'h1);
    chk(bank_o, 12'h000);
    results();
  end

  initial begin
    #100000;
    n_errors++;
    results();
  end
endmodule // boot_strap_gpio_pins_tb
